/* File: afc_checker.sv */
`timescale 1ns/1ps
module afc_checker
  import afc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       filter_download_enable,
  input wire logic [3:0] filter_length_code,
  input wire afc_word_s  dl_word,
  input wire afc_samp_s  samp_in,
  input wire afc_samp_s  samp_out,
  input wire logic       result_valid_flag,
  input wire logic       download_checksum_ok,
  input wire logic       download_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence start_s;
    !download_busy && filter_download_enable && filter_length_code[0];
  endsequence
  // Shortest legal set is six word pairs and a checksum
  sequence words_s;
    download_busy [*3];
  endsequence
  start_busy_a: assert property (start_s |=> words_s)
    else $error("download request not taken");
  idle_stay_a: assert property (!download_busy && !filter_download_enable
    |=> !download_busy) else $error("download began unasked");
  even_refused_a: assert property (!download_busy && !filter_length_code[0]
    |=> !download_busy) else $error("even length code taken");
  // Flag register may lag the state by one cycle
  busy_no_valid_a: assert property (download_busy [*2]
    |-> !result_valid_flag) else $error("valid flag high during download");
  out_pulse_a: assert property (samp_out.valid |=> !samp_out.valid)
    else $error("output valid held");
  out_latency_a: assert property (samp_out.valid
    |-> $past(samp_in.valid, 49)) else $error("output latency wrong");
  ok_answer_a: assert property ($rose(download_checksum_ok)
    |-> $past(dl_word.valid)) else $error("checksum ok without word");
  ok_stands_a: assert property (download_checksum_ok
    && !filter_download_enable |=> download_checksum_ok)
    else $error("checksum ok dropped");
endmodule : afc_checker

bind afc_fir_stage afc_checker i_afc_checker (.sys_clk(sys_clk),
  .rst_n(rst_n), .filter_download_enable(filter_download_enable),
  .filter_length_code(filter_length_code), .dl_word(dl_word),
  .samp_in(samp_in), .samp_out(samp_out),
  .result_valid_flag(result_valid_flag),
  .download_checksum_ok(download_checksum_ok),
  .download_busy(download_busy));

/* File: afc_coef_store.sv */
`timescale 1ns/1ps
// Volatile coefficient memory; reset restores the built-in set
module afc_coef_store
  import afc_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire afc_coef_t        wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output afc_coef_t             rd_data
);
  afc_coef_t mem_q [N_COEF];
  afc_coef_t mem_d [N_COEF];

  always_comb begin
    mem_d = mem_q;
    if (wr_en) begin
      mem_d[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q <= DEF_COEF;
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rd_data = mem_q[rd_idx];
endmodule : afc_coef_store

/* File: afc_fir_stage.sv */
`timescale 1ns/1ps
// Operation
// - Without programming, defaults produce conversion results.
// - Result-valid flag stays clear until full group delay elapses.
// - Third FIR stage accepts user coefficients instead of defaults.
// - Reset loads the built-in default coefficient set.
// - Default filter: 96 taps from 48 stored half coefficients.
// - Only even symmetric responses; stored half is mirrored.
// - Coefficients are sign-magnitude, 26 magnitude bits, sign zero positive.
// - Coefficient count equals half the filter length.
// - Coefficients go from the symmetry point outward, stored alike.
// - Length code 0 is default; odd codes give 6 to 48 coefficients.
// - Byte sum of padded words forms checksum; match sets ok bit.
// - Unused slots zero-filled, half internal clock period each.
// - User coefficients are volatile and lost on reset.
module afc_fir_stage
  import afc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              internal_clock_tick,
  input  wire logic              filter_download_enable,
  input  wire logic [3:0]        filter_length_code,
  input  wire afc_word_s         dl_word,
  input  wire afc_samp_s         samp_in,
  output afc_samp_s              samp_out,
  output logic                   result_valid_flag,
  output logic                   download_checksum_ok,
  output logic                   download_busy
);
  afc_dl_e             st_q, st_d;
  logic [IDX_W-1:0]    wi_q, wi_d;
  logic [IDX_W:0]      ncoef_q, ncoef_d;
  logic [CSUM_W-1:0]   sum_q, sum_d;
  logic [WORD_W-1:0]   hi_q, hi_d;
  logic                ok_q, ok_d;
  logic                fill_ph_q, fill_ph_d;
  logic                mem_we;
  logic [IDX_W-1:0]    mem_wi;
  afc_coef_t           mem_wd;

  // Odd codes map in steps of 6 coefficients; even nonzero codes are not legal lengths
  function automatic logic [IDX_W:0] coef_count(input logic [3:0] code);
    logic [IDX_W:0] n;
    n = 7'h00;
    if (code[0]) begin
      n = 7'(({3'h0, code} + 7'h01) >> 1) * 7'(COEF_STEP);
    end
    return n;
  endfunction : coef_count

  function automatic logic [CSUM_W-1:0] byte_sum(input logic [WORD_W-1:0] w);
    return CSUM_W'(w[15:8]) + CSUM_W'(w[7:0]);
  endfunction : byte_sum

  always_comb begin
    st_d      = st_q;
    wi_d      = wi_q;
    ncoef_d   = ncoef_q;
    sum_d     = sum_q;
    hi_d      = hi_q;
    ok_d      = ok_q;
    fill_ph_d = fill_ph_q;
    mem_we    = 1'b0;
    mem_wi    = wi_q;
    mem_wd    = '0;
    unique case (st_q)
      AFC_IDLE: begin
        if (filter_download_enable && coef_count(filter_length_code) != 0) begin
          st_d    = AFC_HIGH;
          ncoef_d = coef_count(filter_length_code);
          wi_d    = '0;
          sum_d   = '0;
          ok_d    = 1'b0;
        end
      end
      AFC_HIGH: begin
        if (dl_word.valid) begin
          hi_d  = dl_word.data;
          sum_d = sum_q + byte_sum(dl_word.data);
          st_d  = AFC_LOW;
        end
      end
      AFC_LOW: begin
        if (dl_word.valid) begin
          mem_we = 1'b1;
          // Pad bits above the sign are dropped
          mem_wd = {hi_q[10], hi_q[9:0], dl_word.data};
          sum_d  = sum_q + byte_sum(dl_word.data);
          wi_d   = wi_q + 6'h01;
          st_d   = (7'(wi_q) + 7'h01 == ncoef_q) ? AFC_CSUM : AFC_HIGH;
        end
      end
      AFC_CSUM: begin
        if (dl_word.valid) begin
          ok_d      = (dl_word.data == sum_q);
          fill_ph_d = 1'b0;
          st_d      = (ncoef_q == 7'(N_COEF)) ? AFC_IDLE : AFC_FILL;
        end
      end
      AFC_FILL: begin
        // Second slot of a tick goes in the following cycle
        if (internal_clock_tick || fill_ph_q) begin
          mem_we    = 1'b1;
          mem_wd    = '0;
          wi_d      = wi_q + 6'h01;
          fill_ph_d = internal_clock_tick;
          if (7'(wi_q) == 7'(N_COEF - 1)) begin
            st_d = AFC_IDLE;
          end
        end
      end
      default: st_d = AFC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= AFC_IDLE;
      wi_q      <= '0;
      ncoef_q   <= '0;
      sum_q     <= '0;
      hi_q      <= '0;
      ok_q      <= 1'b0;
      fill_ph_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      wi_q      <= wi_d;
      ncoef_q   <= ncoef_d;
      sum_q     <= sum_d;
      hi_q      <= hi_d;
      ok_q      <= ok_d;
      fill_ph_q <= fill_ph_d;
    end
  end

  assign download_checksum_ok = ok_q;
  assign download_busy        = (st_q != AFC_IDLE);

  // FIR datapath: one product per cycle over the 48-deep mirrored half
  afc_coef_t                      coef_rd;
  logic [SAMP_W-1:0]              hist_q [TAPS_MAX];
  logic [SAMP_W-1:0]              hist_d [TAPS_MAX];
  logic [IDX_W-1:0]               k_q, k_d;
  logic                           run_q, run_d;
  logic signed [ACC_W+MAG_W-1:0]  acc_q, acc_d;
  afc_samp_s                      out_q, out_d;
  logic [IDX_W:0]                 gd_q, gd_d;
  logic                           vld_q, vld_d;
  logic signed [SAMP_W:0]         pair;
  logic signed [ACC_W+MAG_W-1:0]  prod;
  logic [IDX_W:0]                 active_n;

  afc_coef_store u_store (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (mem_we),
    .wr_idx  (mem_wi),
    .wr_data (mem_wd),
    .rd_idx  (k_q),
    .rd_data (coef_rd)
  );

  // Short user filters have zero-filled upper slots, so all 48 run
  assign active_n = (ncoef_q == 0) ? GD_DEFAULT : ncoef_q;

  always_comb begin
    hist_d = hist_q;
    k_d    = k_q;
    run_d  = run_q;
    acc_d  = acc_q;
    out_d  = out_q;
    out_d.valid = 1'b0;
    gd_d   = gd_q;
    vld_d  = vld_q;
    // Mirror: stored tap k pairs history around the centre
    pair = $signed({hist_q[47 - k_q][SAMP_W-1], hist_q[47 - k_q]})
         + $signed({hist_q[48 + k_q][SAMP_W-1], hist_q[48 + k_q]});
    // Scaled once at the end so truncation costs under one output LSB
    prod = pair * $signed({1'b0, coef_rd[MAG_W-1:0]});
    if (coef_rd[SIGN_BIT]) begin
      prod = -prod;
    end
    if (samp_in.valid && !run_q) begin
      for (int i = TAPS_MAX - 1; i > 0; i--) begin
        hist_d[i] = hist_q[i-1];
      end
      hist_d[0] = samp_in.data;
      run_d = 1'b1;
      k_d   = '0;
      acc_d = '0;
    end else if (run_q) begin
      acc_d = acc_q + prod;
      k_d   = k_q + 6'h01;
      if (7'(k_q) == 7'(N_COEF - 1)) begin
        run_d      = 1'b0;
        k_d        = '0;
        out_d.valid = 1'b1;
        out_d.data = SAMP_W'(acc_d >>> MAG_W);
        if (gd_q != active_n) begin
          gd_d = gd_q + 7'h01;
        end else begin
          vld_d = 1'b1;
        end
      end
    end
    if (download_busy) begin
      gd_d  = '0;
      vld_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_q <= '{default: '0};
      k_q    <= '0;
      run_q  <= 1'b0;
      acc_q  <= '0;
      out_q  <= '0;
      gd_q   <= '0;
      vld_q  <= 1'b0;
    end else begin
      hist_q <= hist_d;
      k_q    <= k_d;
      run_q  <= run_d;
      acc_q  <= acc_d;
      out_q  <= out_d;
      gd_q   <= gd_d;
      vld_q  <= vld_d;
    end
  end

  assign samp_out          = out_q;
  assign result_valid_flag = vld_q;
endmodule : afc_fir_stage

/* File: afc_fir_stage_tb.sv */
`timescale 1ns/1ps
module afc_fir_stage_tb;
  import afc_pkg::*;
  logic              sys_clk;
  logic              rst_n;
  logic              internal_clock_tick;
  logic              filter_download_enable;
  logic              result_valid_flag;
  logic              download_checksum_ok;
  logic              download_busy;
  logic [3:0]        filter_length_code;
  logic [SAMP_W-1:0] last_y;
  afc_word_s         dl_word;
  afc_samp_s         samp_in;
  afc_samp_s         samp_out;
  int                cyc;
  int                error_cnt;
  int                n_compared;

  afc_fir_stage i_afc_fir_stage (.sys_clk(sys_clk), .rst_n(rst_n),
    .internal_clock_tick(internal_clock_tick), .filter_download_enable(filter_download_enable),
    .filter_length_code(filter_length_code), .dl_word(dl_word),
    .samp_in(samp_in), .samp_out(samp_out),
    .result_valid_flag(result_valid_flag),
    .download_checksum_ok(download_checksum_ok),
    .download_busy(download_busy));
  afc_host_model i_afc_host_model (.sys_clk(sys_clk),
    .filter_download_enable(filter_download_enable),
    .filter_length_code(filter_length_code), .dl_word(dl_word));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    internal_clock_tick <= (cyc[1:0] == 2'h0);
    if (samp_out.valid === 1'b1) last_y <= samp_out.data;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic feed(input int n);
    repeat (n) begin
      @(posedge sys_clk) samp_in <= '{1'b1, 24'h0003e8};
      @(posedge sys_clk) samp_in.valid <= 1'b0;
      repeat (50) @(posedge sys_clk);
    end
  endtask : feed

  task automatic wait_idle();
    @(negedge sys_clk);
    // Room for 42 fill slots at two per four-cycle tick, plus margin
    for (int i = 0; i < 168 / SLOTS_PER_TICK + 12 && download_busy !== 1'b0;
      i++) @(negedge sys_clk);
    check(32'(download_busy), 32'h0);
    repeat (2) @(negedge sys_clk);
  endtask : wait_idle

  task automatic t_reset();
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(32'({samp_out.valid, result_valid_flag, download_checksum_ok,
      download_busy}), 32'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // Power, divider, rate and alignment steps have no pins here
    repeat (5) @(posedge sys_clk);
    $display("reset test done");
  endtask : t_reset

  task automatic t_default();
    feed(40);
    check(32'(result_valid_flag), 32'h0);
    feed(60);
    check(32'(result_valid_flag), 32'h1);
    // Default half set sums to full scale: DC gain is about 2.000
    check(32'(last_y >= 24'h0007ce && last_y <= 24'h0007d0),
      32'h1);
    $display("default filter test done");
  endtask : t_default

  task automatic t_user();
    i_afc_host_model.download(4'h1, 1'b0);
    wait_idle();
    check(32'(download_checksum_ok), 32'h1);
    check(32'(result_valid_flag), 32'h0);
    feed(20);
    check(32'(result_valid_flag), 32'h1);
    check(32'(last_y), 32'h000003e8);
    $display("user filter test done");
  endtask : t_user

  task automatic t_refuse();
    i_afc_host_model.start(4'h2);
    @(negedge sys_clk);
    check(32'(download_busy), 32'h0);
    i_afc_host_model.download(4'hf, 1'b1);
    wait_idle();
    check(32'(download_checksum_ok), 32'h0);
    $display("refused download test done");
  endtask : t_refuse

  initial begin
    rst_n = 1'b0;
    internal_clock_tick = 1'b0;
    samp_in = '0;
    last_y = '0;
    cyc = 0;
    error_cnt = 0;
    n_compared = 0;
    t_reset();
    t_default();
    t_user();
    t_refuse();
    t_reset();
    t_default();
    tally_and_finish();
  end
endmodule : afc_fir_stage_tb

/* File: afc_host_model.sv */
`timescale 1ns/1ps
module afc_host_model
  import afc_pkg::*;
(
  input  wire logic sys_clk,
  output logic      filter_download_enable,
  output logic [3:0] filter_length_code,
  output afc_word_s dl_word
);
  initial begin
    filter_download_enable = 1'b0;
    filter_length_code     = FILTER_LENGTH_CODE_DEFAULT;
    dl_word                = '0;
  end
  task automatic start(input logic [3:0] code);
    @(posedge sys_clk) filter_download_enable <= 1'b1;
    filter_length_code <= code;
    repeat (2) @(posedge sys_clk);
    filter_download_enable <= 1'b0;
  endtask : start
  task automatic send(input logic [15:0] w);
    @(posedge sys_clk) dl_word <= '{1'b1, w};
  endtask : send
  task automatic download(input logic [3:0] code, input logic bad);
    logic [15:0] sum;
    logic [15:0] hi;
    int          n;
    sum = 16'h0000;
    n = (int'(code) + 1) / 2 * COEF_STEP;
    start(code);
    for (int k = 0; k < n; k++) begin
      // Centre tap at half gain first; outer taps are zero, negative at odd k
      hi = (k == 0) ? 16'h0200 : {5'h00, k[0], 10'h000};
      sum = sum + 16'(hi[15:8]) + 16'(hi[7:0]);
      send(hi);
      send(16'h0000);
    end
    send(sum + 16'(bad));
    // Released bus clears valid and shows inverted data, so stale words never look valid
    @(posedge sys_clk) dl_word <= '{1'b0, ~dl_word.data};
  endtask : download
endmodule : afc_host_model

/* File: afc_pkg.sv */
package afc_pkg;
  localparam int unsigned COEF_W     = 27;
  localparam int unsigned MAG_W      = 26;
  localparam int unsigned SIGN_BIT   = 26;
  localparam int unsigned N_COEF     = 48;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned TAPS_MAX   = 96;
  localparam int unsigned COEF_STEP  = 6;
  localparam int unsigned CSUM_W     = 16;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned ACC_W      = 40;
  localparam int unsigned SAMP_W     = 24;
  localparam logic [3:0]  FILTER_LENGTH_CODE_DEFAULT = 4'h0;
  localparam logic [4:0]  PAD_ZERO   = 5'h00;
  // Zero fill: half an internal clock period per slot, so two slots per tick
  localparam int unsigned SLOTS_PER_TICK = 2;
  // Group delay of a filter in output samples is its coefficient count
  localparam logic [IDX_W:0] GD_DEFAULT = 7'h30;

  typedef logic [COEF_W-1:0] afc_coef_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } afc_word_s;

  typedef struct packed {
    logic              valid;
    logic [SAMP_W-1:0] data;
  } afc_samp_s;

  typedef enum logic [2:0] {
    AFC_IDLE  = 3'b000,
    AFC_HIGH  = 3'b001,
    AFC_LOW   = 3'b011,
    AFC_CSUM  = 3'b010,
    AFC_FILL  = 3'b110
  } afc_dl_e;

  localparam afc_coef_t DEF_COEF [N_COEF] = '{
    27'h332bca0, 27'h17fa5a0, 27'h444a196, 27'h4b62067, 27'h4140c31,
    27'h06a734e, 27'h031dddb, 27'h439e6b2, 27'h4392e4a, 27'h01709d9,
    27'h0344ef8, 27'h001397f, 27'h428c5fc, 27'h4101f74, 27'h01a92fb,
    27'h016ebf8, 27'h40cc178, 27'h4175250, 27'h0016dba, 27'h0135efe,
    27'h006466d, 27'h40d2f26, 27'h40a242e, 27'h006a139, 27'h00ab1af,
    27'h401150a, 27'h408e917, 27'h402af3e, 27'h005ee3b, 27'h0047c70,
    27'h402cbd2, 27'h4049e05, 27'h0003ea2, 27'h003a2eb, 27'h00158ca,
    27'h4022f65, 27'h401f797, 27'h000ca52, 27'h001dc13, 27'h000402a,
    27'h401619c, 27'h400f99b, 27'h000b0b2, 27'h001c020, 27'h0018fd5,
    27'h000cdbd, 27'h0003cc7, 27'h00007ab};
endpackage : afc_pkg
